//--- shared/sbcwd_pkg.sv
// sbcwd_pkg: constants, modes and structs for the supervision block
package sbcwd_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000;

  // watchdog periods, ms, indexed by the two period select bits
  localparam int unsigned WD_P0_MS      = 10;
  localparam int unsigned WD_P1_MS      = 45;
  localparam int unsigned WD_P2_MS      = 100;
  localparam int unsigned WD_P3_MS      = 350;
  // supervision period before the host has configured the device, ms
  localparam int unsigned UNCONF_MS     = 350;
  // reset pulse width, ms
  localparam int unsigned RST_PULSE_MS  = 15;
  // stop wake-up interrupt pulse, us
  localparam int unsigned IRQ_PULSE_US  = 10;
  localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_US * CYC_PER_US;
  // forced wake-up and cyclic sense timing, ms; switch on time, us
  localparam int unsigned FWU_MS        = 100;
  localparam int unsigned CYC_SENSE_MS  = 20;
  localparam int unsigned HS_ON_US      = 100;
  localparam int unsigned HS_ON_CYC     = HS_ON_US * CYC_PER_US;

  localparam int unsigned CNT_W         = 26;
  localparam int unsigned IRQ_W         = 11;
  localparam int unsigned WAKE_N        = 4;

  // mode control data values
  localparam logic [2:0] MC_NORMAL      = 3'h5;
  localparam logic [2:0] MC_STANDBY     = 3'h6;
  localparam logic [2:0] MC_STOP        = 3'h3;
  localparam logic [2:0] MC_SLEEP       = 3'h4;

  localparam logic       WIN_RESET      = 1'h1;

  typedef enum logic [2:0] {
    SBCWD_RESET   = 3'b000,
    SBCWD_NORMREQ = 3'b001,
    SBCWD_NORMAL  = 3'b010,
    SBCWD_STANDBY = 3'b011,
    SBCWD_STOP    = 3'b100,
    SBCWD_SLEEP   = 3'b101
  } sbcwd_mode_e;

  // timing_subregister contents
  typedef struct packed {
    logic       window_select_bit;
    logic       period_select_bit_hi;
    logic       period_select_bit_lo;
  } sbcwd_tim_s;

  // low_power_control_register contents
  typedef struct packed {
    logic       input_bias_from_switch;
    logic       timed_wakeup_enable;
    logic       can_wake_enable;
    logic       switch_auto_cycle;
  } sbcwd_lpc_s;

  // wakeup_register read view
  typedef struct packed {
    logic [3:0] wake_flags;
    logic [3:0] wake_levels;
    logic       can_wake_flag;
    logic       cs_wake_flag;
  } sbcwd_wur_s;

endpackage

//--- design/sbcwd_top.sv
// sbcwd_top: window/timeout watchdog, reset outputs and wake-up logic
`timescale 1ns/1ps

module sbcwd_top
  import sbcwd_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // decoded host writes
  input  wire logic               tim_wr,
  input  wire sbcwd_pkg::sbcwd_tim_s tim_wdata,
  input  wire logic               mode_wr,
  input  wire logic [2:0]         mode_wdata,
  input  wire logic               lpc_wr,
  input  wire sbcwd_pkg::sbcwd_lpc_s lpc_wdata,
  input  wire logic               sens_wr,
  input  wire logic [1:0]         sens_wdata,
  input  wire logic               wur_rd,
  // pins and monitors
  input  wire logic [3:0]         wake_inputs,
  input  wire logic               chip_select_n,
  input  wire logic               can_wake_event,
  input  wire logic               main_regulator_ok,
  // outputs
  output logic                    reset_out_n,
  output logic                    fault_indicator_out,
  output logic                    irq_out_n,
  output logic                    main_regulator_on,
  output logic                    high_side_switch,
  output sbcwd_pkg::sbcwd_wur_s   wakeup_register,
  output sbcwd_pkg::sbcwd_mode_e  mode_out
);

  localparam logic [CNT_W-1:0] RST_CYC   = CNT_W'(RST_PULSE_MS * CYC_MS);
  localparam logic [CNT_W-1:0] UNCONF_CYC = CNT_W'(UNCONF_MS * CYC_MS);
  localparam logic [CNT_W-1:0] FWU_CYC   = CNT_W'(FWU_MS * CYC_MS);
  localparam logic [CNT_W-1:0] CS_CYC    = CNT_W'(CYC_SENSE_MS * CYC_MS);

  function automatic logic [CNT_W-1:0] period_cyc(input logic [1:0] sel);
    unique case (sel)
      2'b00: period_cyc = CNT_W'(WD_P0_MS * CYC_MS);
      2'b01: period_cyc = CNT_W'(WD_P1_MS * CYC_MS);
      2'b10: period_cyc = CNT_W'(WD_P2_MS * CYC_MS);
      2'b11: period_cyc = CNT_W'(WD_P3_MS * CYC_MS);
    endcase
  endfunction

  sbcwd_mode_e      mode_reg;
  sbcwd_tim_s       tim_reg;
  sbcwd_lpc_s       lpc_reg;
  logic [1:0]       sens_reg;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [CNT_W-1:0] lp_cnt_reg;
  logic [IRQ_W-1:0] irq_cnt_reg;
  logic             configured_reg;
  logic             fault_reg;
  logic             cs_prev_reg;
  logic             was_stop_reg;
  logic [3:0]       wflag_reg;
  logic             canf_reg;
  logic             csf_reg;
  logic             hs_reg;
  logic             reset_n_reg;

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic             wd_active;
  logic [CNT_W-1:0] wd_period;
  logic             closed_hit;
  logic             wd_expire;
  logic             wd_fail;
  logic             in_low_power;

  assign in_low_power = (mode_reg == SBCWD_STOP) || (mode_reg == SBCWD_SLEEP);
  assign wd_active  = (mode_reg == SBCWD_NORMAL) || (mode_reg == SBCWD_STANDBY) ||
                      (mode_reg == SBCWD_NORMREQ);
  assign wd_period  = (mode_reg == SBCWD_NORMREQ) ? UNCONF_CYC :
                      period_cyc({tim_reg.period_select_bit_hi, tim_reg.period_select_bit_lo});
  // closed interval is the first half of the period
  assign closed_hit = tim_wr && tim_reg.window_select_bit && (mode_reg != SBCWD_NORMREQ) &&
                      (mode_reg != SBCWD_STOP) && (wd_cnt_reg < (wd_period >> 1));
  assign wd_expire  = wd_active && !tim_wr && (wd_cnt_reg >= wd_period - 1'b1);
  assign wd_fail    = wd_active && (closed_hit || wd_expire);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tim_reg <= '{window_select_bit: WIN_RESET, default: 1'b0};
    end else if (tim_wr) begin
      tim_reg <= tim_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !wd_active || wd_fail || tim_wr) begin
      wd_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // every pass through reset or low power must be confirmed by a fresh service
  always_ff @(posedge ref_clk) begin
    if (!rst_n || mode_reg == SBCWD_RESET || in_low_power) begin
      configured_reg <= 1'b0;
    end else if (tim_wr && !closed_hit) begin
      configured_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  logic wake_any;
  logic cs_rise;
  logic [3:0] lvl_match;
  logic direct_en;
  logic cyclic_en;

  assign cs_rise   = chip_select_n && !cs_prev_reg;
  assign direct_en = !lpc_reg.input_bias_from_switch && !lpc_reg.switch_auto_cycle;
  assign cyclic_en = lpc_reg.input_bias_from_switch && lpc_reg.switch_auto_cycle;
  assign lvl_match = {{2{sens_reg[1]}}, {2{sens_reg[0]}}} ~^ wake_inputs;
  assign wake_any  = in_low_power && ((|wflag_reg) || (|(lvl_match & {4{direct_en || hs_reg}})) ||
                     (lpc_reg.can_wake_enable && can_wake_event) || cs_rise ||
                     (lpc_reg.timed_wakeup_enable && !cyclic_en && lp_cnt_reg >= FWU_CYC));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_reg <= SBCWD_RESET;
    end else if (!main_regulator_ok && mode_reg != SBCWD_SLEEP) begin
      mode_reg <= SBCWD_RESET;
    end else if (wd_fail) begin
      mode_reg <= SBCWD_RESET;
    end else if (wake_any) begin
      mode_reg <= (mode_reg == SBCWD_SLEEP) ? SBCWD_RESET : SBCWD_NORMREQ;
    end else if (mode_reg == SBCWD_RESET) begin
      if (rst_cnt_reg >= RST_CYC - 1'b1) begin
        mode_reg <= SBCWD_NORMREQ;
      end
    end else if (mode_reg == SBCWD_NORMREQ && configured_reg) begin
      mode_reg <= SBCWD_NORMAL;
    end else if (mode_wr && !in_low_power) begin
      unique case (mode_wdata)
        MC_NORMAL:  mode_reg <= SBCWD_NORMAL;
        MC_STANDBY: mode_reg <= SBCWD_STANDBY;
        MC_STOP:    mode_reg <= SBCWD_STOP;
        MC_SLEEP:   mode_reg <= SBCWD_SLEEP;
        default:    mode_reg <= mode_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || mode_reg != SBCWD_RESET || !main_regulator_ok) begin
      rst_cnt_reg <= '0;
    end else begin
      rst_cnt_reg <= rst_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // wake-up configuration, sensing and recording
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lpc_reg  <= '0;
      sens_reg <= '0;
    end else begin
      // writes only taken outside low power, as the host is expected to do
      if (lpc_wr && !in_low_power) begin
        lpc_reg <= lpc_wdata;
        if (lpc_wdata.timed_wakeup_enable && lpc_wdata.input_bias_from_switch &&
            lpc_wdata.switch_auto_cycle) begin
          lpc_reg.timed_wakeup_enable <= 1'b0;
        end
      end
      if (sens_wr && !in_low_power) begin
        sens_reg <= sens_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !in_low_power) begin
      lp_cnt_reg <= '0;
      hs_reg     <= 1'b0;
    end else if (cyclic_en) begin
      lp_cnt_reg <= (lp_cnt_reg >= CS_CYC - 1'b1) ? '0 : lp_cnt_reg + 1'b1;
      hs_reg     <= (lp_cnt_reg < CNT_W'(HS_ON_CYC));
    end else begin
      lp_cnt_reg <= (lp_cnt_reg >= FWU_CYC) ? lp_cnt_reg : lp_cnt_reg + 1'b1;
      hs_reg     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= chip_select_n;
    end
  end

  // source flags: a new event wins over the clear on read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wflag_reg <= '0;
      canf_reg  <= 1'b0;
      csf_reg   <= 1'b0;
    end else begin
      wflag_reg <= (wur_rd ? 4'h0 : wflag_reg) |
                   (in_low_power ? lvl_match & {4{direct_en || hs_reg}} : 4'h0);
      canf_reg  <= (wur_rd ? 1'b0 : canf_reg) |
                   (in_low_power && lpc_reg.can_wake_enable && can_wake_event);
      csf_reg   <= (wur_rd ? 1'b0 : csf_reg) | (in_low_power && cs_rise);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
    end else if (wd_fail) begin
      fault_reg <= 1'b1;
    end else if (tim_wr && !closed_hit) begin
      fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      was_stop_reg <= 1'b0;
      irq_cnt_reg  <= '0;
    end else begin
      was_stop_reg <= (mode_reg == SBCWD_STOP);
      if (was_stop_reg && mode_reg == SBCWD_NORMREQ) begin
        irq_cnt_reg <= IRQ_W'(IRQ_PULSE_CYC);
      end else if (irq_cnt_reg != '0) begin
        irq_cnt_reg <= irq_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reset_n_reg         <= 1'b0;
      fault_indicator_out <= 1'b0;
      irq_out_n           <= 1'b1;
      main_regulator_on   <= 1'b1;
      high_side_switch    <= 1'b0;
      wakeup_register     <= '0;
      mode_out            <= SBCWD_RESET;
    end else begin
      reset_n_reg         <= (mode_reg != SBCWD_RESET) && (mode_reg != SBCWD_SLEEP) && main_regulator_ok;
      fault_indicator_out <= !fault_reg;
      irq_out_n           <= (irq_cnt_reg == '0);
      main_regulator_on   <= (mode_reg != SBCWD_SLEEP);
      high_side_switch    <= hs_reg;
      wakeup_register     <= '{wake_flags: wflag_reg, wake_levels: wake_inputs,
                               can_wake_flag: canf_reg, cs_wake_flag: csf_reg};
      mode_out            <= mode_reg;
    end
  end

  assign reset_out_n = reset_n_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_closed_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      (wd_active && closed_hit) |=> ##1 !reset_out_n;
  endproperty
  a_closed_reset: assert property (p_closed_reset) else $error("closed service gave no reset");

  property p_fault_low;
    @(posedge ref_clk) disable iff (!rst_n)
      wd_fail |=> ##1 !fault_indicator_out;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault output did not fall");

  property p_uv_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      (!main_regulator_ok && !fault_reg) |=> !reset_out_n && fault_indicator_out;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("undervoltage reset wrong");

  property p_no_wd_lp;
    @(posedge ref_clk) disable iff (!rst_n)
      in_low_power |=> wd_cnt_reg == '0;
  endproperty
  a_no_wd_lp: assert property (p_no_wd_lp) else $error("watchdog ran in low power");

  property p_stop_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode_reg == SBCWD_STOP && wake_any && !wd_fail && main_regulator_ok) |=> ##2 !irq_out_n;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop wake gave no interrupt");

  property p_sleep_reg;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode_reg == SBCWD_SLEEP) |=> !main_regulator_on;
  endproperty
  a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");

  property p_exclusive;
    @(posedge ref_clk) disable iff (!rst_n)
      !(cyclic_en && lpc_reg.timed_wakeup_enable);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("cyclic and timed wake both on");

  property p_window_rst;
    @(posedge ref_clk)
      !rst_n |=> tim_reg.window_select_bit;
  endproperty
  a_window_rst: assert property (p_window_rst) else $error("window not default");

  property p_levels;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 wakeup_register.wake_levels == $past(wake_inputs);
  endproperty
  a_levels: assert property (p_levels) else $error("wake levels not shown");

endmodule

//--- tb/sbcwd_host_model.sv
// host model: decoded register writes and the chip select pin
`timescale 1ns/1ps

module sbcwd_host_model
  import sbcwd_pkg::*;
(
  // clock
  input  wire logic             ref_clk,
  // decoded writes
  output logic                  tim_wr,
  output sbcwd_pkg::sbcwd_tim_s tim_wdata,
  output logic                  mode_wr,
  output logic [2:0]            mode_wdata,
  output logic                  lpc_wr,
  output sbcwd_pkg::sbcwd_lpc_s lpc_wdata,
  output logic                  sens_wr,
  output logic [1:0]            sens_wdata,
  output logic                  wur_rd,
  // chip select pin
  output logic                  chip_select_n
);
  initial begin
    {tim_wr, mode_wr, lpc_wr, sens_wr, wur_rd} = 5'h00;
    tim_wdata     = '0;
    mode_wdata    = 3'h0;
    lpc_wdata     = '0;
    sens_wdata    = 2'h0;
    chip_select_n = 1'h1;
  end

  // one-cycle strobe; ending on a falling edge keeps back-to-back calls apart
  task automatic wr(input logic [2:0] sel, input logic [3:0] d);
    @(negedge ref_clk);
    case (sel)
      3'h0: begin
        tim_wdata <= sbcwd_tim_s'(d[2:0]);
        tim_wr    <= 1'h1;
      end
      3'h1: begin
        mode_wdata <= d[2:0];
        mode_wr    <= 1'h1;
      end
      3'h2: begin
        lpc_wdata <= sbcwd_lpc_s'(d);
        lpc_wr    <= 1'h1;
      end
      3'h3: begin
        sens_wdata <= d[1:0];
        sens_wr    <= 1'h1;
      end
      default: begin
        wur_rd <= 1'h1;
      end
    endcase
    @(negedge ref_clk);
    {tim_wr, mode_wr, lpc_wr, sens_wr, wur_rd} <= 5'h00;
  endtask

  // low then high on chip select wakes a device in a low power mode
  task automatic cs_wake();
    @(negedge ref_clk);
    chip_select_n <= 1'h0;
    repeat (3) @(negedge ref_clk);
    chip_select_n <= 1'h1;
    @(negedge ref_clk);
  endtask
endmodule

//--- tb/test_sbcwd_top.sv
// testbench of the supervision block: watchdog, reset outputs, wake-up
`timescale 1ns/1ps

module test_sbcwd_top;
  import sbcwd_pkg::*;
  // shortened millisecond keeps the run small
  localparam int CM  = 10;
  localparam int PLS = RST_PULSE_MS * CM;

  logic                  ref_clk;
  logic                  rst_n;
  logic                  tim_wr;
  sbcwd_tim_s            tim_wdata;
  logic                  mode_wr;
  logic [2:0]            mode_wdata;
  logic                  lpc_wr;
  sbcwd_lpc_s            lpc_wdata;
  logic                  sens_wr;
  logic [1:0]            sens_wdata;
  logic                  wur_rd;
  logic [3:0]            wake_inputs;
  logic                  chip_select_n;
  logic                  can_wake_event;
  logic                  main_regulator_ok;
  logic                  reset_out_n;
  logic                  fault_indicator_out;
  logic                  irq_out_n;
  logic                  main_regulator_on;
  logic                  high_side_switch;
  sbcwd_wur_s            wakeup_register;
  sbcwd_mode_e           mode_out;
  int                    error_cnt;
  int                    checked;
  int                    n;

  sbcwd_top #(.CYC_MS(CM)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .tim_wr(tim_wr), .tim_wdata(tim_wdata),
    .mode_wr(mode_wr), .mode_wdata(mode_wdata), .lpc_wr(lpc_wr), .lpc_wdata(lpc_wdata), .sens_wr(sens_wr),
    .sens_wdata(sens_wdata), .wur_rd(wur_rd), .wake_inputs(wake_inputs), .chip_select_n(chip_select_n),
    .can_wake_event(can_wake_event), .main_regulator_ok(main_regulator_ok), .reset_out_n(reset_out_n),
    .fault_indicator_out(fault_indicator_out), .irq_out_n(irq_out_n), .main_regulator_on(main_regulator_on),
    .high_side_switch(high_side_switch), .wakeup_register(wakeup_register), .mode_out(mode_out));

  sbcwd_host_model host (.ref_clk(ref_clk), .tim_wr(tim_wr), .tim_wdata(tim_wdata), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .lpc_wr(lpc_wr), .lpc_wdata(lpc_wdata), .sens_wr(sens_wr),
    .sens_wdata(sens_wdata), .wur_rd(wur_rd), .chip_select_n(chip_select_n));

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic near(input int v, input int exp, input int tol, input string what);
    chk(10'(v >= exp - tol && v <= exp + tol), 10'h001, what);
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return reset_out_n;
      1: return irq_out_n;
      2: return main_regulator_on;
      default: return high_side_switch;
    endcase
  endfunction

  // bounded wait; a limit reached shows up in the count compared afterwards
  task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (sig(sel) !== v && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked = 0;
    rst_n = 1'h0;
    wake_inputs = 4'h0;
    can_wake_event = 1'h0;
    main_regulator_ok = 1'h1;
    cyc(6);
    rst_n <= 1'h1;
    cyc(2);
    chk(10'(reset_out_n), 10'h000, "power-up reset");
    wait_for(0, 1'h1, 500, n);
    near(n, PLS - 2, 5, "power-up pulse");
    chk(10'(mode_out), 10'(SBCWD_NORMREQ), "normal request");
    wait_for(0, 1'h0, 5000, n);
    near(n, UNCONF_MS * CM, 5, "unconfigured repeat");
    wait_for(0, 1'h1, 500, n);
    $display("test power-up done");
    host.wr(3, 4'h0);
    host.wr(0, 4'h4);
    cyc(3);
    chk(10'(mode_out), 10'(SBCWD_NORMAL), "first service");
    for (int i = 0; i < 4; i++) begin
      cyc(70);
      host.wr(0, 4'h4);
    end
    chk(10'({reset_out_n, fault_indicator_out}), 10'h003, "open window");
    cyc(20);
    host.wr(0, 4'h4);
    wait_for(0, 1'h0, 20, n);
    near(n, 2, 3, "closed window");
    chk(10'(fault_indicator_out), 10'h000, "fault on service error");
    wait_for(0, 1'h1, 500, n);
    chk(10'(fault_indicator_out), 10'h000, "fault held");
    host.wr(0, 4'h4);
    cyc(3);
    chk(10'(fault_indicator_out), 10'h001, "fault cleared");
    wait_for(0, 1'h0, 300, n);
    near(n, WD_P0_MS * CM - 2, 6, "timeout 10");
    $display("test window done");
    wait_for(0, 1'h1, 500, n);
    host.wr(0, 4'h0);
    for (int i = 0; i < 3; i++) begin
      cyc(10);
      host.wr(0, 4'h0);
    end
    chk(10'(reset_out_n), 10'h001, "timeout mode");
    host.wr(0, 4'h1);
    wait_for(0, 1'h0, 900, n);
    near(n, WD_P1_MS * CM, 6, "period select");
    wait_for(0, 1'h1, 500, n);
    host.wr(0, 4'h4);
    $display("test timeout done");
    wake_inputs <= 4'hA;
    cyc(3);
    chk(10'(wakeup_register.wake_levels), 10'h00A, "input port");
    wake_inputs <= 4'hF;
    main_regulator_ok <= 1'h0;
    cyc(20);
    chk(10'({reset_out_n, fault_indicator_out}), 10'h001, "undervoltage");
    main_regulator_ok <= 1'h1;
    wait_for(0, 1'h1, 500, n);
    near(n, PLS, 10, "undervoltage recovery");
    host.wr(0, 4'h4);
    host.wr(1, 4'(MC_SLEEP));
    cyc(3);
    chk(10'({main_regulator_on, mode_out}), 10'({1'h0, SBCWD_SLEEP}), "sleep");
    host.cs_wake();
    cyc(3);
    chk(10'({main_regulator_on, reset_out_n}), 10'h002, "sleep wake");
    chk(10'(wakeup_register.cs_wake_flag), 10'h001, "cs source");
    wait_for(0, 1'h1, 500, n);
    near(n, PLS, 10, "sleep wake reset");
    host.wr(0, 4'h4);
    host.wr(4, 4'h0);
    cyc(2);
    chk(10'(wakeup_register.cs_wake_flag), 10'h000, "flag read clear");
    $display("test sleep done");
    host.wr(2, 4'h2);
    host.wr(1, 4'(MC_STOP));
    cyc(3);
    chk(10'({irq_out_n, mode_out}), 10'({1'h1, SBCWD_STOP}), "stop");
    can_wake_event <= 1'h1;
    wait_for(1, 1'h0, 20, n);
    can_wake_event <= 1'h0;
    wait_for(1, 1'h1, 1200, n);
    near(n, IRQ_PULSE_CYC, 3, "stop irq width");
    chk(10'(mode_out), 10'(SBCWD_NORMREQ), "stop wake mode");
    chk(10'(wakeup_register.can_wake_flag), 10'h001, "can source");
    host.wr(0, 4'h4);
    host.wr(2, 4'h4);
    host.wr(1, 4'(MC_SLEEP));
    cyc(2);
    wait_for(2, 1'h1, 1300, n);
    near(n, FWU_MS * CM, 8, "forced wake");
    wait_for(0, 1'h1, 500, n);
    host.wr(0, 4'h4);
    $display("test stop done");
    host.wr(2, 4'hD);
    host.wr(1, 4'(MC_SLEEP));
    wait_for(3, 1'h1, 400, n);
    chk(10'(n < 400), 10'h001, "cyclic switch");
    wait_for(2, 1'h1, 1300, n);
    chk(10'(main_regulator_on), 10'h000, "no timed wake");
    host.cs_wake();
    $display("test cyclic done");
    stop_test();
  end
endmodule
